/* logic/pts_cfg.svh */
// constants for the power table shaping block
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
`define PTS_TABLE_DEPTH   8
`define PTS_IDX_W         3
`define PTS_LEVEL_W       8
`define PTS_LEVEL_RESET   8'hc6
`define PTS_LEVEL_ZERO    8'h00
`define PTS_STEPS_PER_SYM 8
`define PTS_DIV_W         16
`endif

/* logic/pts_pkg.sv */
// types for the power table shaping block
`default_nettype none
package pts_pkg;
  typedef enum logic [2:0] {
    PTS_OFF    = 3'h0,
    PTS_RAMPUP = 3'h1,
    PTS_HOLD   = 3'h2,
    PTS_RAMPDN = 3'h3,
    PTS_ASK    = 3'h4
  } pts_state_t;

  typedef struct packed {
    logic       en;
    logic       burst;
    logic [2:0] addr;
    logic [7:0] data;
  } pts_wr_t;
endpackage
`default_nettype wire

/* logic/pts_power_table.sv */
// power level table, shaping counter and core power control
// How it works
// - eight programmable power level entries
// - three-bit limit picks highest used entry
// - ramp up through entries to limit, hold, reverse when transmit ends
// - chip select low wakes core, serial out low once oscillator ready
// - power-down strobe acts when chip select high
// - entry zero resets to default setting
// - non-zero entries written only in burst
// - sleep keeps entry zero, clears others
// - ASK counter up on one, down zero
// - counter steps at eight times symbol rate
// - counter saturates at limit and zero
// - counter value indexes the power table
`timescale 1ns/1ps
`include "pts_cfg.svh"
`default_nettype none
module pts_power_table (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_resetn,
  input  wire pts_pkg::pts_wr_t          i_wr,
  input  wire logic [`PTS_IDX_W-1:0]     i_power_index_limit,
  input  wire logic                      i_ask_mode,
  input  wire logic                      i_tx_active,
  input  wire logic                      i_tx_symbol,
  input  wire logic [`PTS_DIV_W-1:0]     i_tick_div,
  input  wire logic                      i_sleep,
  input  wire logic                      i_power_down_strobe,
  input  wire logic                      i_csn,
  input  wire logic                      i_osc_ready,
  output logic [`PTS_LEVEL_W-1:0]        o_pa_level,
  output logic [`PTS_IDX_W-1:0]          o_index,
  output logic                           o_tx_busy,
  output logic                           o_core_power_en,
  output logic                           o_osc_en,
  output logic                           o_so_ready_low
);
  logic [`PTS_LEVEL_W-1:0] table_mem [`PTS_TABLE_DEPTH];
  logic [`PTS_LEVEL_W-1:0] next_table [`PTS_TABLE_DEPTH];
  logic [2:0]              csn_sync;
  logic [2:0]              next_csn_sync;
  logic                    csn_q;
  logic                    next_csn_q;
  logic                    pd_pending;
  logic                    next_pd_pending;
  logic                    powered;
  logic                    next_powered;
  logic [`PTS_DIV_W-1:0]   div_cnt;
  logic [`PTS_DIV_W-1:0]   next_div_cnt;
  logic [`PTS_IDX_W-1:0]   idx;
  logic [`PTS_IDX_W-1:0]   next_idx;
  pts_pkg::pts_state_t     state;
  pts_pkg::pts_state_t     next_state;
  logic [`PTS_LEVEL_W-1:0] next_pa_level;
  logic                    next_so_ready_low;
  logic                    tick;

  // table writes and sleep loss
  always_comb begin
    for (int i = 0; i < `PTS_TABLE_DEPTH; i++) begin
      next_table[i] = table_mem[i];
    end
    if (i_sleep) begin
      for (int i = 1; i < `PTS_TABLE_DEPTH; i++) begin
        next_table[i] = `PTS_LEVEL_ZERO;
      end
    end else if (i_wr.en) begin
      // single access reaches entry zero only
      if (i_wr.burst) begin
        next_table[i_wr.addr] = i_wr.data;
      end else begin
        next_table[0] = i_wr.data;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      table_mem[0] <= `PTS_LEVEL_RESET;
      for (int i = 1; i < `PTS_TABLE_DEPTH; i++) begin
        table_mem[i] <= `PTS_LEVEL_ZERO;
      end
    end else begin
      for (int i = 0; i < `PTS_TABLE_DEPTH; i++) begin
        table_mem[i] <= next_table[i];
      end
    end
  end

  // chip select sync and core power control
  always_comb begin
    next_csn_sync   = {csn_sync[1:0], i_csn};
    next_csn_q      = csn_q;
    if (csn_sync[1] == csn_sync[2]) begin
      next_csn_q = csn_sync[2];
    end
    next_pd_pending = pd_pending | i_power_down_strobe;
    next_powered    = powered;
    // power off only once chip select high
    if (pd_pending && next_csn_q) begin
      next_powered    = 1'b0;
      next_pd_pending = i_power_down_strobe;
    end
    if (!next_csn_q) begin
      next_powered = 1'b1;
    end
    next_so_ready_low = !next_csn_q && powered && i_osc_ready;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      csn_sync        <= 3'h7;
      csn_q           <= 1'b1;
      pd_pending      <= 1'b0;
      powered         <= 1'b1;
      o_core_power_en <= 1'b1;
      o_osc_en        <= 1'b1;
      o_so_ready_low  <= 1'b0;
    end else begin
      csn_sync        <= next_csn_sync;
      csn_q           <= next_csn_q;
      pd_pending      <= next_pd_pending;
      powered         <= next_powered;
      o_core_power_en <= next_powered;
      o_osc_en        <= next_powered;
      o_so_ready_low  <= next_so_ready_low;
    end
  end

  // tick at eight per symbol, period set by divider
  assign tick = (div_cnt == '0);

  always_comb begin
    next_div_cnt = tick ? i_tick_div : div_cnt - 1'b1;
    next_state   = state;
    next_idx     = idx;
    case (state)
      pts_pkg::PTS_OFF: begin
        next_idx = '0;
        if (i_tx_active) begin
          next_state = i_ask_mode ? pts_pkg::PTS_ASK : pts_pkg::PTS_RAMPUP;
        end
      end
      pts_pkg::PTS_RAMPUP: begin
        if (!i_tx_active) begin
          next_state = pts_pkg::PTS_RAMPDN;
        end else if (idx >= i_power_index_limit) begin
          next_idx   = i_power_index_limit;
          next_state = pts_pkg::PTS_HOLD;
        end else if (tick) begin
          next_idx = idx + 1'b1;
        end
      end
      pts_pkg::PTS_HOLD: begin
        next_idx = i_power_index_limit;
        if (!i_tx_active) begin
          next_state = pts_pkg::PTS_RAMPDN;
        end
      end
      pts_pkg::PTS_RAMPDN: begin
        if (i_tx_active) begin
          next_state = pts_pkg::PTS_RAMPUP;
        end else if (idx == '0) begin
          next_state = pts_pkg::PTS_OFF;
        end else if (tick) begin
          next_idx = idx - 1'b1;
        end
      end
      pts_pkg::PTS_ASK: begin
        // up on one, down on zero
        if (!i_tx_active) begin
          next_state = pts_pkg::PTS_RAMPDN;
        end else if (tick) begin
          if (i_tx_symbol) begin
            if (idx < i_power_index_limit) begin
              next_idx = idx + 1'b1;
            end else begin
              next_idx = i_power_index_limit;
            end
          end else if (idx != '0) begin
            next_idx = idx - 1'b1;
          end
        end
      end
      default: begin
        next_state = pts_pkg::PTS_OFF;
        next_idx   = '0;
      end
    endcase
    next_pa_level = (next_state == pts_pkg::PTS_OFF) ? `PTS_LEVEL_ZERO : table_mem[next_idx];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      div_cnt    <= '0;
      state      <= pts_pkg::PTS_OFF;
      idx        <= '0;
      o_pa_level <= `PTS_LEVEL_ZERO;
      o_index    <= '0;
      o_tx_busy  <= 1'b0;
    end else begin
      div_cnt    <= next_div_cnt;
      state      <= next_state;
      idx        <= next_idx;
      o_pa_level <= next_pa_level;
      o_index    <= next_idx;
      o_tx_busy  <= (next_state != pts_pkg::PTS_OFF);
    end
  end
endmodule
`default_nettype wire

/* testbench/pts_sva.sv */
// assertion checker for the power table shaping block
`timescale 1ns/1ps
`default_nettype none
module pts_sva (
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  input wire logic       i_tx_active,
  input wire logic       i_csn,
  input wire logic       i_osc_ready,
  input wire logic [2:0] i_power_index_limit,
  input wire logic [7:0] o_pa_level,
  input wire logic [2:0] o_index,
  input wire logic       o_tx_busy,
  input wire logic       o_core_power_en,
  input wire logic       o_osc_en,
  input wire logic       o_so_ready_low
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  idle_level_a: assert property (!o_tx_busy |-> o_pa_level == 8'h00)
    else $error("level not zero when idle");
  start_busy_a: assert property (!o_tx_busy && i_tx_active |=> o_tx_busy)
    else $error("transmit not started");
  start_index_a: assert property ($rose(o_tx_busy) |-> o_index == 3'h0)
    else $error("ramp not from entry zero");
  index_limit_a: assert property (o_tx_busy |-> o_index <= i_power_index_limit)
    else $error("index above limit");
  index_step_a: assert property (o_tx_busy && $past(o_tx_busy) |->
    o_index == $past(o_index) || o_index == $past(o_index) + 3'h1 ||
    o_index == $past(o_index) - 3'h1) else $error("index jumped");
  power_off_a: assert property ($fell(o_core_power_en) |-> $past(i_csn, 2))
    else $error("power removed while selected");
  osc_power_a: assert property (o_osc_en == o_core_power_en)
    else $error("oscillator and core disagree");
  ready_low_a: assert property ($rose(o_so_ready_low) |->
    !$past(i_csn, 3) && $past(i_osc_ready)) else $error("ready without select");
  power_on_a: assert property ($rose(o_core_power_en) |-> !$past(i_csn, 2))
    else $error("power restored while deselected");
  ramp_end_a: assert property ($fell(o_tx_busy) |-> $past(o_index) == 3'h0)
    else $error("ramp did not end at entry zero");
endmodule
bind pts_power_table pts_sva chk_u (.i_clk_sys, .i_resetn, .i_tx_active, .i_csn,
  .i_osc_ready, .i_power_index_limit, .o_pa_level, .o_index, .o_tx_busy,
  .o_core_power_en, .o_osc_en, .o_so_ready_low);
`default_nettype wire

/* testbench/pts_host_model.sv */
// host model driving table writes, chip select and power-down strobe
`timescale 1ns/1ps
`default_nettype none
module pts_host_model (
  input  wire logic              i_clk_sys,
  output var pts_pkg::pts_wr_t   o_wr,
  output logic                   o_csn,
  output logic                   o_power_down_strobe
);
  initial begin
    o_wr = '0;
    o_csn = 1'b0;
    o_power_down_strobe = 1'b0;
  end
  task automatic write_entry(input logic b, input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_wr = '{en: 1'b1, burst: b, addr: a, data: d};
    @(negedge i_clk_sys);
    o_wr = '{en: 1'b0, burst: ~b, addr: ~a, data: ~d};
  endtask
  task automatic strobe();
    @(negedge i_clk_sys);
    o_power_down_strobe = 1'b1;
    @(negedge i_clk_sys);
    o_power_down_strobe = 1'b0;
  endtask
  task automatic set_csn(input logic v);
    @(negedge i_clk_sys);
    o_csn = v;
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the power table shaping block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic             clk = 1'b0, resetn = 1'b0, ask = 1'b0, tx = 1'b0, sym = 1'b0;
  logic             sleep = 1'b0, osc_rdy = 1'b1, csn, pds, busy, pwr, osc, rdy;
  logic [2:0]       limit = 3'h0, idx;
  logic [15:0]      div = 16'h0000;
  logic [7:0]       level;
  pts_pkg::pts_wr_t wr;
  int               err_count = 0, samples_checked = 0, n;
  always #20 clk = ~clk;
  pts_host_model host_u (.i_clk_sys(clk), .o_wr(wr), .o_csn(csn), .o_power_down_strobe(pds));
  pts_power_table dut_u (.i_clk_sys(clk), .i_resetn(resetn), .i_wr(wr),
    .i_power_index_limit(limit), .i_ask_mode(ask), .i_tx_active(tx), .i_tx_symbol(sym),
    .i_tick_div(div), .i_sleep(sleep), .i_power_down_strobe(pds), .i_csn(csn),
    .i_osc_ready(osc_rdy), .o_pa_level(level), .o_index(idx), .o_tx_busy(busy),
    .o_core_power_en(pwr), .o_osc_en(osc), .o_so_ready_low(rdy));
  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_idx(input logic [2:0] got, input logic [2:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_change(output int k);
    logic [2:0] prev;
    prev = idx;
    k = 0;
    do begin
      cyc(1);
      k++;
      if (k > 40) begin
        err_count++;
        finish_test();
      end
    end while (idx === prev);
  endtask
  task automatic run_tx(input logic [2:0] lim, input logic [7:0] exp);
    limit = lim;
    tx = 1'b1;
    cyc(12);
    chk_idx(idx, lim);
    chk(level, exp);
    tx = 1'b0;
    cyc(12);
    chk_bit(busy, 1'b0);
    chk(level, 8'h00);
  endtask
  task automatic t_table();
    for (int i = 1; i < 8; i++) host_u.write_entry(1'b1, i[2:0], 8'h30 + i[7:0]);
    host_u.write_entry(1'b0, 3'h3, 8'h3f);
    run_tx(3'h0, 8'h3f);
    run_tx(3'h3, 8'h33);
    run_tx(3'h7, 8'h37);
  endtask
  task automatic t_ramp();
    div = 16'h0003;
    limit = 3'h7;
    tx = 1'b1;
    wait_change(n);
    wait_change(n);
    chk(n[7:0], 8'h04);
    tx = 1'b0;
    cyc(40);
    chk_bit(busy, 1'b0);
    chk_idx(idx, 3'h0);
  endtask
  task automatic t_ask();
    div = 16'h0007;
    ask = 1'b1;
    sym = 1'b1;
    tx = 1'b1;
    wait_change(n);
    wait_change(n);
    chk(n[7:0], 8'h08);
    cyc(80);
    chk_idx(idx, 3'h7);
    chk(level, 8'h37);
    sym = 1'b0;
    cyc(80);
    chk_idx(idx, 3'h0);
    chk_bit(busy, 1'b1);
    tx = 1'b0;
    cyc(10);
    ask = 1'b0;
    div = 16'h0000;
  endtask
  task automatic t_sleep();
    sleep = 1'b1;
    host_u.write_entry(1'b0, 3'h0, 8'h00);
    sleep = 1'b0;
    run_tx(3'h0, 8'h3f);
    run_tx(3'h1, 8'h00);
  endtask
  task automatic wait_ready();
    n = 0;
    while (rdy !== 1'b1) begin
      cyc(1);
      if (++n > 20) begin
        err_count++;
        finish_test();
      end
    end
  endtask
  task automatic t_power();
    host_u.strobe();
    cyc(10);
    chk_bit(pwr, 1'b1);
    host_u.set_csn(1'b1);
    cyc(10);
    chk_bit(pwr, 1'b0);
    chk_bit(osc, 1'b0);
    chk_bit(rdy, 1'b0);
    osc_rdy = 1'b0;
    host_u.set_csn(1'b0);
    cyc(10);
    chk_bit(pwr, 1'b1);
    chk_bit(osc, 1'b1);
    chk_bit(rdy, 1'b0);
    osc_rdy = 1'b1;
    wait_ready();
    chk_bit(rdy, 1'b1);
  endtask
  task automatic t_reset();
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    wait_ready();
    chk_bit(pwr, 1'b1);
    chk_bit(osc, 1'b1);
    run_tx(3'h0, 8'hc6);
  endtask
  initial begin
    t_reset();
    t_table();
    t_ramp();
    t_ask();
    t_sleep();
    t_power();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
